// *** src/mac_acc_regs.vh ***
// mac_acc_regs.vh: constants of the accumulator datapath
// assumes: included by the design files by its bare name
`ifndef MAC_ACC_REGS_VH
`define MAC_ACC_REGS_VH

// data widths
`define MAC_ACC_W        40
`define MAC_WORD_W       16
`define MAC_CNT_W        5
`define MAC_ADDR_W       3

// operation codes on op_code
`define MAC_OP_ABS_ACC   3'h0
`define MAC_OP_ABS_SRC   3'h1
`define MAC_OP_ADD       3'h2
`define MAC_OP_ADD2      3'h3
`define MAC_OP_ASHR      3'h4
`define MAC_OP_ASHR_RND  3'h5

// register offsets (word index on reg_addr)
`define MAC_REG_CTRL     3'h0
`define MAC_REG_STAT     3'h1
`define MAC_REG_ACC_LO   3'h2
`define MAC_REG_ACC_MID  3'h3
`define MAC_REG_ACC_EXT  3'h4

// control word fields
`define MAC_CTRL_SAT_BIT 0

// status word fields
`define MAC_ST_NEG       0
`define MAC_ST_ZERO      1
`define MAC_ST_CARRY     2
`define MAC_ST_SOVF      3
`define MAC_ST_EXT       4
`define MAC_ST_SLIM      5
`define MAC_ST_OVF       6

// reset values
`define MAC_CTRL_RST     16'h0000
`define MAC_STAT_RST     7'h02
`define MAC_ACC_RST      40'h00_0000_0000

// arithmetic constants
`define MAC_MOST_NEG     40'h80_0000_0000
`define MAC_RND_CONST    40'h00_0000_8000
`define MAC_SAT_POS      40'h00_7FFF_FFFF
`define MAC_SAT_NEG      40'hFF_8000_0000
`define MAC_REG_CNT_MASK 5'h0F

`endif

// *** src/mac_sat_flags.v ***
// mac_sat_flags.v: saturation and result flag evaluation
// assumes: input is the exact 41-bit signed result of an operation
`timescale 1ns/1ps
`include "mac_acc_regs.vh"

module mac_sat_flags (
  input  wire [40:0] true_val,
  input  wire        sat_en,
  input  wire        clr_low,
  output reg  [39:0] result,
  output wire        sat_hit,
  output wire        ext_used,
  output wire        zero,
  output wire        neg
);

  wire        in_range;
  wire [39:0] sat_val;

  // value fits the signed 32-bit range when bits 40..31 agree
  assign in_range = (true_val[40:31] == 10'h000) || (true_val[40:31] == 10'h3FF);
  assign sat_hit  = sat_en & ~in_range;                           // [RULE19] [RULE9]
  assign sat_val  = true_val[40] ? `MAC_SAT_NEG : `MAC_SAT_POS;

  // pick saturated or wrapped value, then clear the low product word
  always @* begin
    result = sat_hit ? sat_val : true_val[39:0];                  // [RULE19]
    if (clr_low) begin
      result[15:0] = 16'h0000;                                    // [RULE16]
    end
  end

  // flags of the value actually stored
  assign ext_used = ~((result[39:31] == 9'h000) || (result[39:31] == 9'h1FF)); // [RULE20] [RULE10]
  assign zero     = (result == 40'h00_0000_0000);                 // [RULE11]
  assign neg      = result[39];                                   // [RULE12]

endmodule // mac_sat_flags

// *** src/mac_acc_unit.v ***
// mac_acc_unit.v: 40-bit accumulator with absolute value, add,
// add-doubled and arithmetic right shift, plus the status flags
// assumes: the cpu core drives op_valid for one cycle per operation,
// with sources and shift count valid in that cycle; register port
// strobes are one cycle long and never both at once; immediate shift
// counts stay within 16 and software does not load the accumulator
// while operations are issued
//
// Function
// [RULE1] magnitude without operands replaces accumulator by its absolute value
// [RULE2] that magnitude sets overflow and sticky overflow on most negative value
// [RULE3] two-operand magnitude loads absolute source; clears overflow and carry
// [RULE4] source is high word over low word, sign-extended to 40 bits
// [RULE5] operand sum adds source to accumulator, result back in accumulator
// [RULE6] doubled sum adds twice the source to the accumulator
// [RULE7] adds set overflow when sum exceeds 40 bits; sticky overflow follows
// [RULE8] adds set carry on carry out of the accumulator, clear otherwise
// [RULE9] any automatic saturation sets sticky limit flag, else unchanged
// [RULE10] extension used flag tells whether result occupies extension bits
// [RULE11] zero flag set when 40-bit result is zero
// [RULE12] negative flag copies result most significant bit
// [RULE13] arithmetic right shift keeps the sign in vacated upper bits
// [RULE14] issuer gives shift counts 0 to 16; immediate is 5-bit unsigned
// [RULE15] register-sourced shift count uses only its low four bits
// [RULE16] rounding shift adds 8000h then clears the low product word
// [RULE17] rounding shift carry from rounding add; overflow flags follow overflow
// [RULE18] plain shift result ignores the saturation select bit
// [RULE19] with saturation selected, results clamp to signed 32-bit range
// [RULE20] extension in use when accumulator bits 39 to 31 differ
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "mac_acc_regs.vh"

module mac_acc_unit (
  core_clk,
  rst,
  op_valid,
  op_code,
  src_low,
  src_high,
  shift_cnt,
  shift_imm,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  op_done,
  acc_out,
  flags_out
);

  input  wire                     core_clk;
  input  wire                     rst;
  input  wire                     op_valid;
  input  wire [2:0]               op_code;
  input  wire [`MAC_WORD_W-1:0]   src_low;
  input  wire [`MAC_WORD_W-1:0]   src_high;
  input  wire [`MAC_CNT_W-1:0]    shift_cnt;
  input  wire                     shift_imm;
  input  wire [`MAC_ADDR_W-1:0]   reg_addr;
  input  wire [`MAC_WORD_W-1:0]   reg_wdata;
  input  wire                     reg_wr;
  input  wire                     reg_rd;
  output reg  [`MAC_WORD_W-1:0]   reg_rdata;
  output reg                      op_done;
  output wire [`MAC_ACC_W-1:0]    acc_out;
  output wire [6:0]               flags_out;

  // register map on reg_addr, 16-bit words:
  //   0 control, bit 0 selects saturation
  //   1 status, flag bits 6..0
  //   2 accumulator bits 15..0, the low product word
  //   3 accumulator bits 31..16
  //   4 accumulator bits 39..32 in the low byte, upper byte reads zero
  //   other offsets ignore writes and read zero
  // status layout: 0 negative, 1 zero, 2 carry, 3 sticky overflow,
  //   4 extension used, 5 sticky limit, 6 overflow

  // architectural state
  reg  [`MAC_ACC_W-1:0]  acc_r;
  reg  [`MAC_ACC_W-1:0]  acc_nxt;
  reg  [`MAC_WORD_W-1:0] ctrl_r;
  reg  [6:0]             stat_r;
  reg  [6:0]             stat_nxt;

  // operand forms
  wire [39:0] src40;
  wire [39:0] src2_40;
  wire [40:0] acc_x;
  wire [40:0] src_x;
  wire [40:0] src2_x;

  // magnitudes, sums and carries
  wire [40:0] abs_acc_x;
  wire [40:0] abs_src_x;
  wire [40:0] sum_x;
  wire [40:0] ucar_add;
  wire [40:0] sum2_x;
  wire [40:0] ucar_add2;

  // shift and round
  wire [4:0]  shift_amt;
  wire [39:0] sh40;
  wire [40:0] sh_x;
  wire [40:0] rnd_x;
  wire [40:0] ucar_rnd;

  // flag sources and register selects
  wire        acc_most_neg;
  wire        sat_sel;
  wire        sel_ctrl;
  wire        sel_stat;
  wire        sel_lo;
  wire        sel_mid;
  wire        sel_ext;

  // per-operation selections
  // set by the case below for the code on op_code
  reg  [40:0] true_val;
  reg         sat_en;
  reg         clr_low;
  reg         op_ovf;
  reg         op_carry;
  reg         op_known;

  // evaluated result
  wire [39:0] res;
  wire        res_sat;
  wire        res_ext;
  wire        res_zero;
  wire        res_neg;

  // outputs come straight from the state registers
  assign acc_out   = acc_r;
  assign flags_out = stat_r;
  assign sat_sel   = ctrl_r[`MAC_CTRL_SAT_BIT];

  // source: high word above low word, sign-extended;
  // doubling loses no bit, the source has only 32 significant bits
  assign src40   = {{8{src_high[15]}}, src_high, src_low};          // [RULE4]
  assign src2_40 = {src40[38:0], 1'b0};                             // [RULE6]

  // 41-bit exact forms so overflow and saturation see the true value;
  // bit 40 is the true sign, so bit 40 differing from bit 39 means
  // the result does not fit the 40-bit accumulator
  assign acc_x  = {acc_r[39], acc_r};
  assign src_x  = {src40[39], src40};
  assign src2_x = {src40[39], src2_40};

  // absolute values; most negative accumulator yields +2^39 exactly,
  // which wraps back to the most negative value unless saturation
  // clamps it; the 32-bit source magnitude can never overflow
  assign acc_most_neg = (acc_r == `MAC_MOST_NEG);                   // [RULE2]
  assign abs_acc_x = acc_r[39] ? (41'h0 - acc_x) : acc_x;           // [RULE1]
  assign abs_src_x = src40[39] ? (41'h0 - src_x) : src_x;           // [RULE3]

  // sums, signed for overflow and unsigned for carry; the carry is
  // the bit out of position 39 with both operands taken as unsigned
  assign sum_x     = acc_x + src_x;                                 // [RULE5]
  assign ucar_add  = {1'b0, acc_r} + {1'b0, src40};                 // [RULE8]
  assign sum2_x    = acc_x + src2_x;                                // [RULE6]
  assign ucar_add2 = {1'b0, acc_r} + {1'b0, src2_40};               // [RULE8]

  // shift count: immediate taken whole, register form only low bits;
  // immediate counts above 16 are not guarded, the issuer keeps to 16
  assign shift_amt = shift_imm ? shift_cnt
                               : (shift_cnt & `MAC_REG_CNT_MASK);   // [RULE15]

  // sign-preserving right shift of the accumulator
  assign sh40 = $signed(acc_r) >>> shift_amt;                       // [RULE13]
  assign sh_x = {sh40[39], sh40};

  // rounding add after the shift; the low word is cleared only after
  // saturation, so a clamped positive result ends in 0000
  assign rnd_x    = sh_x + {1'b0, `MAC_RND_CONST};                  // [RULE16]
  assign ucar_rnd = {1'b0, sh40} + {1'b0, `MAC_RND_CONST};          // [RULE17]

  // choose the exact result and flag sources for the operation;
  // unknown codes change nothing and raise no done pulse
  always @* begin
    true_val = acc_x;
    sat_en   = 1'b0;
    clr_low  = 1'b0;
    op_ovf   = 1'b0;
    op_carry = 1'b0;
    op_known = 1'b1;
    case (op_code)
      // in-place magnitude, overflow only from the most negative value
      `MAC_OP_ABS_ACC: begin
        true_val = abs_acc_x;                                       // [RULE1]
        sat_en   = sat_sel;
        op_ovf   = acc_most_neg;                                    // [RULE2]
      end
      // source magnitude, overflow and carry always cleared
      `MAC_OP_ABS_SRC: begin
        true_val = abs_src_x;                                       // [RULE3]
        sat_en   = sat_sel;
      end
      // accumulate the source
      `MAC_OP_ADD: begin
        true_val = sum_x;                                           // [RULE5]
        sat_en   = sat_sel;
        op_ovf   = sum_x[40] ^ sum_x[39];                           // [RULE7]
        op_carry = ucar_add[40];                                    // [RULE8]
      end
      // accumulate twice the source
      `MAC_OP_ADD2: begin
        true_val = sum2_x;                                          // [RULE6]
        sat_en   = sat_sel;
        op_ovf   = sum2_x[40] ^ sum2_x[39];                         // [RULE7]
        op_carry = ucar_add2[40];                                   // [RULE8]
      end
      // plain shift, never saturates, overflow and carry cleared
      `MAC_OP_ASHR: begin
        true_val = sh_x;                                            // [RULE13]
        sat_en   = 1'b0;                                            // [RULE18]
      end
      // shift, round, saturate, then clear the low product word
      `MAC_OP_ASHR_RND: begin
        true_val = rnd_x;                                           // [RULE16]
        sat_en   = sat_sel;
        clr_low  = 1'b1;                                            // [RULE16]
        op_ovf   = rnd_x[40] ^ rnd_x[39];                           // [RULE17]
        op_carry = ucar_rnd[40];                                    // [RULE17]
      end
      default: begin
        op_known = 1'b0;
      end
    endcase
  end

  // saturation, low word clear and result flags
  mac_sat_flags u_sat (
    .true_val (true_val),
    .sat_en   (sat_en),
    .clr_low  (clr_low),
    .result   (res),
    .sat_hit  (res_sat),
    .ext_used (res_ext),
    .zero     (res_zero),
    .neg      (res_neg)
  );

  // register selects
  // offsets above 4 match nothing and read zero
  assign sel_ctrl = (reg_addr == `MAC_REG_CTRL);
  assign sel_stat = (reg_addr == `MAC_REG_STAT);
  assign sel_lo   = (reg_addr == `MAC_REG_ACC_LO);
  assign sel_mid  = (reg_addr == `MAC_REG_ACC_MID);
  assign sel_ext  = (reg_addr == `MAC_REG_ACC_EXT);

  // an operation is taken only for a known code
  wire do_op;
  assign do_op = op_valid & op_known;

  // accumulator next value: operation wins over a software write;
  // a word written in the cycle of an operation is lost, so software
  // must not load the accumulator while the core issues operations
  always @* begin
    acc_nxt = acc_r;
    if (do_op) begin
      acc_nxt = res;                                                // [RULE1] [RULE5]
    end else if (reg_wr) begin
      if (sel_lo) begin
        acc_nxt[15:0] = reg_wdata;
      end
      if (sel_mid) begin
        acc_nxt[31:16] = reg_wdata;
      end
      if (sel_ext) begin
        acc_nxt[39:32] = reg_wdata[7:0];
      end
    end
  end

  // status next value; sticky sets win over a clearing write, so a
  // sticky event is never lost to a clear in the same cycle; the
  // other flags of an operation override the written value
  always @* begin
    stat_nxt = stat_r;
    if (reg_wr && sel_stat) begin
      stat_nxt = reg_wdata[6:0];
    end
    if (do_op) begin
      stat_nxt[`MAC_ST_OVF]   = op_ovf;                             // [RULE2] [RULE7] [RULE17]
      stat_nxt[`MAC_ST_CARRY] = op_carry;                           // [RULE3] [RULE8] [RULE17]
      stat_nxt[`MAC_ST_EXT]   = res_ext;                            // [RULE10]
      stat_nxt[`MAC_ST_ZERO]  = res_zero;                           // [RULE11]
      stat_nxt[`MAC_ST_NEG]   = res_neg;                            // [RULE12]
      if (op_ovf) begin
        stat_nxt[`MAC_ST_SOVF] = 1'b1;                              // [RULE2] [RULE7] [RULE17]
      end
      if (res_sat) begin
        stat_nxt[`MAC_ST_SLIM] = 1'b1;                              // [RULE9]
      end
    end
  end

  // state update
  always @(posedge core_clk) begin
    if (rst) begin
      acc_r   <= `MAC_ACC_RST;
      stat_r  <= `MAC_STAT_RST;
      ctrl_r  <= `MAC_CTRL_RST;
      op_done <= 1'b0;
    end else begin
      acc_r   <= acc_nxt;
      stat_r  <= stat_nxt;
      // done marks each accepted operation for one cycle
      op_done <= do_op;
      if (reg_wr && sel_ctrl) begin
        ctrl_r <= reg_wdata;
      end
    end
  end

  // read data, one cycle after the read strobe; unmapped reads zero;
  // every other cycle reads zero so stale data never shows
  always @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (sel_ctrl) begin
        reg_rdata <= ctrl_r;
      end else if (sel_stat) begin
        reg_rdata <= {9'h000, stat_r};
      end else if (sel_lo) begin
        reg_rdata <= acc_r[15:0];
      end else if (sel_mid) begin
        reg_rdata <= acc_r[31:16];
      end else if (sel_ext) begin
        reg_rdata <= {8'h00, acc_r[39:32]};
      end else begin
        reg_rdata <= 16'h0000;
      end
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule // mac_acc_unit

// *** dv/mac_acc_properties.sv ***
// mac_acc_properties.sv: port-level checks of the accumulator datapath
// assumes: bound to mac_acc_unit; one clock, rst synchronous active high
`timescale 1ns/1ps
module mac_acc_chk (
  input logic        core_clk,
  input logic        rst,
  input logic        op_valid,
  input logic [2:0]  op_code,
  input logic [15:0] src_low,
  input logic [15:0] src_high,
  input logic [4:0]  shift_cnt,
  input logic        shift_imm,
  input logic [2:0]  reg_addr,
  input logic [15:0] reg_wdata,
  input logic        reg_wr,
  input logic        reg_rd,
  input logic [15:0] reg_rdata,
  input logic        op_done,
  input logic [39:0] acc_out,
  input logic [6:0]  flags_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // request handshake, then flags against the result they describe
  chk_done_after_op: assert property (op_valid && op_code <= 3'h5 |=> op_done)
    else $error("no done after a valid operation");
  chk_bad_code_idle: assert property (op_valid && op_code > 3'h5 |=> !op_done)
    else $error("done after an unknown code");
  chk_zero_tracks: assert property (op_done |-> flags_out[1] == (acc_out == 40'h0))
    else $error("zero flag disagrees with result");
  chk_neg_tracks: assert property (op_done |-> flags_out[0] == acc_out[39])
    else $error("negative flag disagrees with result");
  chk_ext_tracks: assert property (op_done |->
    flags_out[4] == !(&acc_out[39:31] || !(|acc_out[39:31])))
    else $error("extension flag disagrees with result");
  chk_abs_src_flags: assert property (op_valid && op_code == 3'h1 && !reg_wr |=>
    !flags_out[6] && !flags_out[2] && flags_out[3] == $past(flags_out[3]))
    else $error("source magnitude flags wrong");
  chk_abs_most_neg: assert property (op_valid && op_code == 3'h0 |=>
    flags_out[6] == ($past(acc_out) == 40'h80_0000_0000))
    else $error("magnitude overflow flag wrong");
  chk_rnd_low_zero: assert property (op_valid && op_code == 3'h5 |=> acc_out[15:0] == 16'h0)
    else $error("rounded shift left low word set");
  chk_shift_sign: assert property (op_valid && op_code == 3'h4 |=>
    acc_out[39] == $past(acc_out[39]) && !flags_out[2])
    else $error("shift lost the sign");
  chk_slim_sticky: assert property (op_valid && !reg_wr |=> !$fell(flags_out[5]))
    else $error("sticky limit cleared by an operation");
endmodule // mac_acc_chk

bind mac_acc_unit mac_acc_chk u_mac_acc_chk (
  .core_clk(core_clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
  .src_low(src_low), .src_high(src_high), .shift_cnt(shift_cnt), .shift_imm(shift_imm),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .op_done(op_done), .acc_out(acc_out), .flags_out(flags_out)
);

// *** dv/mac_host_model.sv ***
// mac_host_model.sv: cpu core side that issues accumulator operations
// assumes: the bench calls issue; one operation in flight at a time
`timescale 1ns/1ps
module mac_host_model (
  input  wire        core_clk,
  output reg         op_valid,
  output reg  [2:0]  op_code,
  output reg  [15:0] src_low,
  output reg  [15:0] src_high,
  output reg  [4:0]  shift_cnt,
  output reg         shift_imm
);
  // idle until the first request
  initial begin
    op_valid  = 1'b0;
    op_code   = 3'h0;
    src_low   = 16'h0000;
    src_high  = 16'h0000;
    shift_cnt = 5'h00;
    shift_imm = 1'b1;
  end

  // one-cycle request; sources are scrambled after so no stale word helps
  task issue(input [2:0] c, input [15:0] lo, input [15:0] hi, input [4:0] n, input imm);
    begin
      @(posedge core_clk);
      op_valid  <= 1'b1;
      op_code   <= c;
      src_low   <= lo;
      src_high  <= hi;
      shift_cnt <= (imm && n > 5'h10) ? 5'h10 : n;
      shift_imm <= imm;
      @(posedge core_clk);
      op_valid  <= 1'b0;
      src_low   <= ~lo;
      src_high  <= ~hi;
      shift_cnt <= ~n;
    end
  endtask
endmodule // mac_host_model

// *** dv/mac_accumulator_abs_add_shift_tb_top.sv ***
// mac_accumulator_abs_add_shift_tb_top.sv: self-checking bench of the accumulator
// assumes: 25 MHz core_clk, host model drives the operation port
`timescale 1ns/1ps
module mac_accumulator_abs_add_shift_tb_top;
  reg         core_clk, rst, reg_wr, reg_rd;
  reg  [2:0]  reg_addr;
  reg  [15:0] reg_wdata, d;
  wire        op_valid, shift_imm, op_done;
  wire [2:0]  op_code;
  wire [15:0] src_low, src_high, reg_rdata;
  wire [4:0]  shift_cnt;
  wire [39:0] acc_out;
  wire [6:0]  flags_out;
  integer     fails, total_checks, i, n;
  reg  [87:0] rows [0:8];

  mac_acc_unit u_mac_acc_unit (.core_clk(core_clk), .rst(rst), .op_valid(op_valid),
    .op_code(op_code), .src_low(src_low), .src_high(src_high), .shift_cnt(shift_cnt),
    .shift_imm(shift_imm), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_done(op_done), .acc_out(acc_out),
    .flags_out(flags_out));
  mac_host_model u_mac_host_model (.core_clk(core_clk), .op_valid(op_valid),
    .op_code(op_code), .src_low(src_low), .src_high(src_high), .shift_cnt(shift_cnt),
    .shift_imm(shift_imm));

  // 40 ns clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // verdict and end of run
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  // compare and count
  task chk(input [39:0] seen, input [39:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask

  // register port cycles
  task wr(input [2:0] a, input [15:0] v);
    begin
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
    end
  endtask
  task rd(input [2:0] a, output [15:0] v);
    begin
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1 v = reg_rdata;
    end
  endtask

  // one operation, bounded wait for its done pulse
  task run_op(input [2:0] c, input [15:0] lo, input [15:0] hi, input [4:0] k, input imm);
    begin
      u_mac_host_model.issue(c, lo, hi, k, imm);
      #1 n = 0;
      while (op_done !== 1'b1 && n < 4) begin
        @(posedge core_clk);
        #1 n = n + 1;
      end
      if (op_done !== 1'b1) begin
        fails = fails + 1;
        tally_and_finish;
      end
    end
  endtask

  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    fails = 0;
    total_checks = 0;
    // op, low, high, count, imm, accumulator, flags; saturation off
    rows[0] = {3'h2, 16'h0001, 16'h0000, 5'h00, 1'b1, 40'h00_0000_0001, 7'h00};
    rows[1] = {3'h3, 16'hFFFF, 16'hFFFF, 5'h00, 1'b1, 40'hFF_FFFF_FFFF, 7'h01};
    rows[2] = {3'h2, 16'h0001, 16'h0000, 5'h00, 1'b1, 40'h00_0000_0000, 7'h06};
    rows[3] = {3'h1, 16'h0000, 16'h8000, 5'h00, 1'b1, 40'h00_8000_0000, 7'h10};
    rows[4] = {3'h4, 16'h0000, 16'h0000, 5'h10, 1'b1, 40'h00_0000_8000, 7'h00};
    rows[5] = {3'h5, 16'h0000, 16'h0000, 5'h10, 1'b0, 40'h00_0001_0000, 7'h00};
    rows[6] = {3'h2, 16'h0000, 16'h8000, 5'h00, 1'b1, 40'hFF_8001_0000, 7'h01};
    rows[7] = {3'h4, 16'h0000, 16'h0000, 5'h04, 1'b1, 40'hFF_F800_1000, 7'h01};
    rows[8] = {3'h0, 16'h0000, 16'h0000, 5'h00, 1'b1, 40'h00_07FF_F000, 7'h00};
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    #1 chk(acc_out, 40'h0);
    chk(flags_out, 7'h02);
    for (i = 0; i < 9; i = i + 1) begin
      run_op(rows[i][87:85], rows[i][84:69], rows[i][68:53], rows[i][52:48], rows[i][47]);
      chk(acc_out, rows[i][46:7]);
      chk(flags_out, rows[i][6:0]);
    end
    // most negative accumulator wraps and raises both overflow flags
    wr(3'h4, 16'h0080);
    wr(3'h3, 16'h0000);
    wr(3'h2, 16'h0000);
    run_op(3'h0, 16'h0000, 16'h0000, 5'h00, 1'b1);
    chk(acc_out, 40'h80_0000_0000);
    rd(3'h1, d);
    chk(d, 16'h0059);
    rd(3'h7, d);
    chk(d, 16'h0000);
    // saturation selected: clamp to 32-bit range and set sticky limit
    wr(3'h0, 16'h0001);
    run_op(3'h2, 16'h0000, 16'h4000, 5'h00, 1'b1);
    chk(acc_out, 40'hFF_8000_0000);
    chk(flags_out, 7'h29);
    // doubled add past the 40-bit range wraps with saturation off
    wr(3'h0, 16'h0000);
    wr(3'h1, 16'h0000);
    wr(3'h4, 16'h007F);
    wr(3'h3, 16'hFFFF);
    wr(3'h2, 16'hFFFF);
    run_op(3'h3, 16'h0001, 16'h0000, 5'h00, 1'b1);
    chk(acc_out, 40'h80_0000_0001);
    chk(flags_out, 7'h59);
    // read back each accumulator word, then the idle zero
    rd(3'h2, d);
    chk(d, 16'h0001);
    rd(3'h3, d);
    chk(d, 16'h0000);
    rd(3'h4, d);
    chk(d, 16'h0080);
    @(posedge core_clk);
    #1 chk(reg_rdata, 16'h0000);
    // unknown code is ignored
    u_mac_host_model.issue(3'h6, 16'h1234, 16'h0000, 5'h00, 1'b1);
    #1 chk(op_done, 1'b0);
    chk(acc_out, 40'h80_0000_0001);
    // plain shift never saturates even when selected
    wr(3'h0, 16'h0001);
    rd(3'h0, d);
    chk(d, 16'h0001);
    run_op(3'h4, 16'h0000, 16'h0000, 5'h01, 1'b1);
    chk(acc_out, 40'hC0_0000_0000);
    chk(flags_out, 7'h19);
    @(posedge core_clk);
    #1 chk(op_done, 1'b0);
    // rounding add carries out of the top bit
    wr(3'h4, 16'h00FF);
    wr(3'h3, 16'hFFFF);
    wr(3'h2, 16'h8000);
    run_op(3'h5, 16'h0000, 16'h0000, 5'h00, 1'b1);
    chk(acc_out, 40'h0);
    chk(flags_out, 7'h0E);
    // reset in mid-run: idle values, saturation deselected again
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    #1 chk(acc_out, 40'h0);
    chk(flags_out, 7'h02);
    run_op(3'h3, 16'hFFFF, 16'h7FFF, 5'h00, 1'b1);
    chk(acc_out, 40'h00_FFFF_FFFE);
    chk(flags_out, 7'h10);
    tally_and_finish;
  end
endmodule // mac_accumulator_abs_add_shift_tb_top
